/* File: radar_pulse_timing_sequencer.sv */
// Radar interpulse-period timing sequencer with comb and coded exciter reference
//
// Overview of operation
// - Every emitted timing pulse lasts exactly one microsecond.
// - Host programs period length, default 37 ms; sequence restarts each period.
// - Transmitter power start precedes RF drive start by 0.16 ms.
// - Receiver blanking is issued before RF drive start, default 1.820 ms.
// - RF drive start and stop bracket only the 1.04 ms transmission.
// - Receiver re-enable follows RF stop later, defaults 3.000 and 3.500 ms.
// - Calibration start/stop pulses only when control-room enable is set.
// - Every on and off event has its own output line.
// - Monitor sync pulse near period start, default 0.010 ms.
// - Range-gate reset, range-gate start and position-counter clear go to status logic.
// - Range sync passes from one of two sources chosen by static select.
// - Sampling comb every 10 us, referenced to selectable 5 MHz source.
// - Backup data mode switches comb spacing to 500 us.
// - Gated 2 MHz coded reference from 4 MHz, enabled between RF start and stop.
// - Phase code is a 13-element Barker code, 80 us per element.
// - Exciter modes: unmodulated, Barker-modulated, inhibited.
// - Receive gates open on receiver enable, close on receiver blank.
// - Host selects 0/180 mixer phase by command bit 20 and records it.
`timescale 1ns/1ps
`include "pulse_seq_defines.svh"

module radar_pulse_timing_sequencer
  import pulse_seq_pkg::*;
#(
  parameter int TW = 24
) (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  input  wire logic        REF_SEL,
  input  wire logic        REF_5M_STD,
  input  wire logic        REF_5M_WFG,
  input  wire logic        RSYNC_SEL,
  input  wire logic        RSYNC_WFG,
  input  wire logic        RSYNC_STAT,
  input  wire logic        PRETRIG,
  input  wire logic [12:0] CODE_PATTERN,
  output pulse_vec_t       PULSES,
  output logic             RANGE_SYNC,
  output logic             SAMPLE_COMB,
  output logic             CODED_REF,
  output logic             RX_GATE,
  output logic             MIXER_PHASE
);

  // Synchronisers for pins from outside the clock domain
  logic [1:0]  s_std, s_wfg, s_rs_w, s_rs_s, s_sel, s_rsel, s_pre;
  logic [12:0] code_meta_r, code_sync_r; // Static pattern still comes from a pin
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_std  <= 2'h0;
      s_wfg  <= 2'h0;
      s_rs_w <= 2'h0;
      s_rs_s <= 2'h0;
      s_sel  <= 2'h0;
      s_rsel <= 2'h0;
      s_pre  <= 2'h0;
      code_meta_r <= 13'h0000;
      code_sync_r <= 13'h0000;
    end else begin
      s_std  <= {s_std[0], REF_5M_STD};
      s_wfg  <= {s_wfg[0], REF_5M_WFG};
      s_rs_w <= {s_rs_w[0], RSYNC_WFG};
      s_rs_s <= {s_rs_s[0], RSYNC_STAT};
      s_sel  <= {s_sel[0], REF_SEL};
      s_rsel <= {s_rsel[0], RSYNC_SEL};
      s_pre  <= {s_pre[0], PRETRIG};
      code_meta_r <= CODE_PATTERN;
      code_sync_r <= code_meta_r;
    end
  end

  // Registers: period, twelve event times, control
  logic [TW-1:0] period_r;
  logic [TW-1:0] evt_r [12];
  logic          cal_en_r;
  logic          backup_r;
  exc_mode_t     mode_r;
  logic          phase_r;
  logic [31:0]   phase_log_r;

  function automatic logic [TW-1:0] evt_reset(input int i);
    case (i)
      0:       evt_reset = TW'(`RST_SYNC);
      1:       evt_reset = TW'(`RST_TXON);
      2:       evt_reset = TW'(`RST_RXOFF);
      3:       evt_reset = TW'(`RST_RFON);
      4:       evt_reset = TW'(`RST_RFOFF);
      5:       evt_reset = TW'(`RST_TXOFF);
      6:       evt_reset = TW'(`RST_RXON);
      7:       evt_reset = TW'(`RST_CALON);
      8:       evt_reset = TW'(`RST_CALOFF);
      9:       evt_reset = TW'(`RST_RGRST);
      10:      evt_reset = TW'(`RST_RGSTART);
      default: evt_reset = TW'(`RST_POSCLR);
    endcase
  endfunction

  // Host writes to the period and event offsets
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      period_r <= TW'(`RST_PERIOD);
      for (int i = 0; i < 12; i++) begin
        evt_r[i] <= evt_reset(i);
      end
    end else if (WR) begin
      if (ADDR == `A_PERIOD) begin
        period_r <= WDATA[TW-1:0];
      end else if (ADDR >= `A_SYNC && ADDR <= `A_POSCLR) begin
        evt_r[ADDR - `A_SYNC] <= WDATA[TW-1:0];
      end
    end
  end

  // Control bits; phase select is taken from bit 20 as the elevation word carries it
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cal_en_r <= 1'b0;
      backup_r <= 1'b0;
      mode_r   <= MODE_INHIBIT;
      phase_r  <= 1'b0;
    end else if (WR && ADDR == `A_CTRL) begin
      cal_en_r <= WDATA[`CTRL_CAL_EN];
      backup_r <= WDATA[`CTRL_BACKUP];
      mode_r   <= (WDATA[`CTRL_MODE_LO+1:`CTRL_MODE_LO] == 2'h1) ? MODE_UNMOD :
                  (WDATA[`CTRL_MODE_LO+1:`CTRL_MODE_LO] == 2'h2) ? MODE_BARKER : MODE_INHIBIT;
      phase_r  <= WDATA[20];
    end
  end

  // Period counter at microsecond resolution
  logic [4:0]    us_div_r;
  logic          us_tick;
  logic [TW-1:0] pcount_r;
  logic          period_wrap;
  assign us_tick     = (us_div_r == 5'(`US_CYC - 1));
  assign period_wrap = us_tick && (pcount_r >= period_r - TW'(1));

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      us_div_r <= 5'h0;
    end else begin
      us_div_r <= us_tick ? 5'h0 : us_div_r + 5'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pcount_r <= '0;
    end else if (us_tick) begin
      pcount_r <= period_wrap ? '0 : pcount_r + TW'(1);
    end
  end

  // Record of each period's mixer phase, one bit per period, shifted in at wrap
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_log_r <= 32'h0000_0000;
    end else if (period_wrap) begin
      phase_log_r <= {phase_log_r[30:0], phase_r};
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      MIXER_PHASE <= 1'b0;
    end else if (period_wrap) begin
      MIXER_PHASE <= phase_r; // Changes only between periods
    end
  end

  // Event hits: one-clock starts when counter enters the programmed microsecond
  logic [12:0] hit;
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      hit[i] = us_tick && (pcount_r + TW'(1) == evt_r[i]) && !period_wrap;
    end
    hit[12] = period_wrap;
    hit[7]  = hit[7] && cal_en_r;
    hit[8]  = hit[8] && cal_en_r;
  end

  // Pulse stretchers: one counter per line so no line is shared
  logic [4:0] stretch_r [13];
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 13; i++) begin
        stretch_r[i] <= 5'h0;
      end
    end else begin
      for (int i = 0; i < 13; i++) begin
        if (hit[i]) begin
          stretch_r[i] <= 5'(`PULSE_CYC);
        end else if (stretch_r[i] != 5'h0) begin
          stretch_r[i] <= stretch_r[i] - 5'h1;
        end
      end
    end
  end

  // Each event drives its own line defaults give ..spacing
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PULSES <= '0;
    end else begin
      PULSES.sync       <= hit[0]  || (stretch_r[0]  > 5'h1);
      PULSES.tx_on      <= hit[1]  || (stretch_r[1]  > 5'h1);
      PULSES.rx_off     <= hit[2]  || (stretch_r[2]  > 5'h1);
      PULSES.rf_on      <= hit[3]  || (stretch_r[3]  > 5'h1);
      PULSES.rf_off     <= hit[4]  || (stretch_r[4]  > 5'h1);
      PULSES.tx_off     <= hit[5]  || (stretch_r[5]  > 5'h1);
      PULSES.rx_on      <= hit[6]  || (stretch_r[6]  > 5'h1);
      PULSES.cal_on     <= hit[7]  || (stretch_r[7]  > 5'h1);
      PULSES.cal_off    <= hit[8]  || (stretch_r[8]  > 5'h1);
      PULSES.rg_rst     <= hit[9]  || (stretch_r[9]  > 5'h1);
      PULSES.rg_start   <= hit[10] || (stretch_r[10] > 5'h1);
      PULSES.pos_clr    <= hit[11] || (stretch_r[11] > 5'h1);
      PULSES.period_end <= hit[12] || (stretch_r[12] > 5'h1);
    end
  end

  // Receive gate: opens on re-enable, closes on blanking
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_GATE <= 1'b0;
    end else if (hit[2]) begin
      RX_GATE <= 1'b0;
    end else if (hit[6]) begin
      RX_GATE <= 1'b1;
    end
  end

  // Range sync pass-through from the selected source
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RANGE_SYNC <= 1'b0;
    end else begin
      RANGE_SYNC <= s_rsel[1] ? s_rs_s[1] : s_rs_w[1];
    end
  end

  // Sampling comb: 5 MHz reference edges counted, 5 per microsecond
  logic       ref_d_r;
  logic       ref_rise;
  logic [2:0] ref_cnt_r;
  logic [8:0] comb_us_r;
  logic       comb_hit;
  assign ref_rise = (s_sel[1] ? s_wfg[1] : s_std[1]) && !ref_d_r;
  assign comb_hit = ref_rise && ref_cnt_r == 3'h4 &&
                    comb_us_r == (backup_r ? 9'(`COMB_BACKUP_US - 1) : 9'(`COMB_STD_US - 1));

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_d_r   <= 1'b0;
      ref_cnt_r <= 3'h0;
      comb_us_r <= 9'h0;
    end else begin
      ref_d_r <= s_sel[1] ? s_wfg[1] : s_std[1];
      if (ref_rise) begin
        ref_cnt_r <= (ref_cnt_r == 3'h4) ? 3'h0 : ref_cnt_r + 3'h1;
        if (ref_cnt_r == 3'h4) begin
          comb_us_r <= comb_hit ? 9'h0 : comb_us_r + 9'h1;
        end
      end
    end
  end

  // Comb pulse held one microsecond
  logic [4:0] comb_str_r;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      comb_str_r  <= 5'h0;
      SAMPLE_COMB <= 1'b0;
    end else begin
      comb_str_r  <= comb_hit ? 5'(`PULSE_CYC) : (comb_str_r != 5'h0 ? comb_str_r - 5'h1 : 5'h0);
      SAMPLE_COMB <= comb_hit || comb_str_r > 5'h1;
    end
  end

  // Coded reference: 2 MHz square from a 4 MHz internal phase, gated by RF window
  logic       rf_win_r;
  logic [2:0] q4_div_r;
  logic       clk4_r;
  logic       carrier_r;
  logic [10:0] baud_cnt_r;
  logic [3:0] chip_r;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rf_win_r <= 1'b0;
    end else if (hit[3]) begin
      rf_win_r <= 1'b1;
    end else if (hit[4]) begin
      rf_win_r <= 1'b0;
    end
  end

  // 4 MHz strobe once every five clocks; the carrier toggles on each strobe, giving 2 MHz
  // Runs from MCLK, so it is not locked to the selected 5 MHz reference
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      q4_div_r  <= 3'h0;
      clk4_r    <= 1'b0;
      carrier_r <= 1'b0;
    end else if (s_pre[1]) begin
      q4_div_r  <= 3'h0; // Pretrigger presets the phase
      clk4_r    <= 1'b0;
      carrier_r <= 1'b0;
    end else begin
      q4_div_r <= (q4_div_r == 3'(`CARRIER_HALF_CYC - 1)) ? 3'h0 : q4_div_r + 3'h1;
      clk4_r   <= (q4_div_r == 3'(`CARRIER_HALF_CYC - 1));
      if (clk4_r) begin
        carrier_r <= !carrier_r;
      end
    end
  end

  // Barker chip sequencing: 13 elements of 80 us from RF start
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      baud_cnt_r <= 11'h0;
      chip_r     <= 4'h0;
    end else if (s_pre[1] || hit[3]) begin
      baud_cnt_r <= 11'h0;
      chip_r     <= 4'h0;
    end else if (rf_win_r && chip_r < 4'(`BARKER_LEN)) begin
      if (baud_cnt_r == 11'(`BAUD_US * `US_CYC - 1)) begin
        baud_cnt_r <= 11'h0;
        chip_r     <= chip_r + 4'h1;
      end else begin
        baud_cnt_r <= baud_cnt_r + 11'h1;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CODED_REF <= 1'b0;
    end else begin
      case (mode_r)
        MODE_UNMOD:  CODED_REF <= rf_win_r && carrier_r;
        MODE_BARKER: CODED_REF <= rf_win_r && chip_r < 4'(`BARKER_LEN) &&
                                  (carrier_r ^ !code_sync_r[4'd12 - chip_r]);
        default:     CODED_REF <= 1'b0;
      endcase
    end
  end

  // Register read-back, one cycle after the strobe
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      if (ADDR == `A_PERIOD) begin
        RDATA <= 32'(period_r);
      end else if (ADDR >= `A_SYNC && ADDR <= `A_POSCLR) begin
        RDATA <= 32'(evt_r[ADDR - `A_SYNC]);
      end else if (ADDR == `A_CTRL) begin
        RDATA <= {11'h0, phase_r, 16'h0, mode_r, backup_r, cal_en_r};
      end else if (ADDR == `A_STATUS) begin
        RDATA <= 32'({2'h0, RX_GATE, rf_win_r, chip_r, pcount_r});
      end else begin
        RDATA <= phase_log_r;
      end
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule

/* File: pulse_seq_defines.svh */
// Offsets, reset values and timing counts for the radar pulse timing sequencer
`ifndef PULSE_SEQ_DEFINES_SVH
`define PULSE_SEQ_DEFINES_SVH

`define CLK_HZ            20000000
`define PULSE_NS          1000
`define PULSE_CYC         ((`PULSE_NS * (`CLK_HZ / 1000000)) / 1000)
`define US_CYC            (`CLK_HZ / 1000000)
`define COMB_STD_US       10
`define COMB_BACKUP_US    500
`define BAUD_US           80
`define BARKER_LEN        13
`define BARKER_CODE       13'h1F35
`define CARRIER_HALF_CYC  5

// Register offsets
`define A_PERIOD          4'h0
`define A_SYNC            4'h1
`define A_TXON            4'h2
`define A_RXOFF           4'h3
`define A_RFON            4'h4
`define A_RFOFF           4'h5
`define A_TXOFF           4'h6
`define A_RXON            4'h7
`define A_CALON           4'h8
`define A_CALOFF          4'h9
`define A_RGRST           4'hA
`define A_RGSTART         4'hB
`define A_POSCLR          4'hC
`define A_CTRL            4'hD
`define A_STATUS          4'hE

// Reset event times in microseconds
`define RST_PERIOD        24'd37000
`define RST_SYNC          24'd10
`define RST_TXON          24'd1800
`define RST_RXOFF         24'd1820
`define RST_RFON          24'd1960
`define RST_RFOFF         24'd3000
`define RST_TXOFF         24'd3000
`define RST_RXON          24'd3500
`define RST_CALON         24'd11960
`define RST_CALOFF        24'd13000
`define RST_RGRST         24'd1950
`define RST_RGSTART       24'd1960
`define RST_POSCLR        24'd1950

// Control register fields
`define CTRL_CAL_EN       0
`define CTRL_BACKUP       1
`define CTRL_MODE_LO      2
`define CTRL_PHASE        4
`endif

/* File: pulse_seq_pkg.sv */
// Types shared by the radar pulse timing sequencer
package pulse_seq_pkg;
  typedef enum logic [1:0] {MODE_INHIBIT, MODE_UNMOD, MODE_BARKER} exc_mode_t;
  typedef struct packed {
    logic sync;
    logic tx_on;
    logic rx_off;
    logic rf_on;
    logic rf_off;
    logic tx_off;
    logic rx_on;
    logic cal_on;
    logic cal_off;
    logic rg_rst;
    logic rg_start;
    logic pos_clr;
    logic period_end;
  } pulse_vec_t;
endpackage

/* File: pulse_seq_checker_assertions.sv */
// Port-level assertions for the radar pulse timing sequencer
`timescale 1ns/1ps
module pulse_seq_checker
  import pulse_seq_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic       RSYNC_SEL,
  input wire logic       RSYNC_WFG,
  input wire logic       RSYNC_STAT,
  input wire pulse_vec_t PULSES,
  input wire logic       RANGE_SYNC,
  input wire logic       SAMPLE_COMB,
  input wire logic       CODED_REF,
  input wire logic       RX_GATE,
  input wire logic       MIXER_PHASE
);
  logic [13:0] lines;
  logic        rs_mux;
  logic [4:0]  hi_r [14];
  logic [2:0]  age_r;
  logic [1:0]  idle_r;
  logic        win_r;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Comb joins the event lines so one counter set covers every pulse
  assign lines  = {PULSES, SAMPLE_COMB};
  assign rs_mux = RSYNC_SEL ? RSYNC_STAT : RSYNC_WFG;
  // High time per line; saturates so a stuck line cannot wrap back into range
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 14; i++)
        hi_r[i] <= 5'h0;
    end else begin
      for (int i = 0; i < 14; i++)
        if (!lines[i])
          hi_r[i] <= 5'h0;
        else if (hi_r[i] != 5'h1F)
          hi_r[i] <= hi_r[i] + 5'h1;
    end
  end
  // Cycles since reset and since the RF window closed, both saturating
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      age_r  <= 3'h0;
      idle_r <= 2'h0;
      win_r  <= 1'b0;
    end else begin
      if (age_r != 3'h7)
        age_r <= age_r + 3'h1;
      if (PULSES.rf_off)
        win_r <= 1'b0;
      else if (PULSES.rf_on)
        win_r <= 1'b1;
      if (win_r)
        idle_r <= 2'h0;
      else if (idle_r != 2'h3)
        idle_r <= idle_r + 2'h1;
    end
  end
  for (genvar g = 0; g < 14; g++) begin : g_line
    a_pulse_not_long: assert property (lines[g] |-> hi_r[g] < 5'h14)
      else $error("timing line high too long");
    a_pulse_not_short: assert property ($fell(lines[g]) |-> hi_r[g] == 5'h14)
      else $error("timing line dropped early");
  end
  a_gate_closes: assert property ($rose(PULSES.rx_off) |-> ##[0:1] !RX_GATE)
    else $error("receive gate open after blank pulse");
  a_gate_opens: assert property ($rose(PULSES.rx_on) |-> ##[0:1] RX_GATE)
    else $error("receive gate shut after enable pulse");
  a_gate_cause: assert property ($changed(RX_GATE) |-> ##[0:1] (PULSES.rx_on || PULSES.rx_off))
    else $error("receive gate moved without a pulse");
  a_range_pass: assert property (age_r > 3'h3 |-> RANGE_SYNC == $past(rs_mux, 3))
    else $error("range sync not passed from selected source");
  a_ref_gated: assert property (idle_r == 2'h3 && !PULSES.rf_on |-> !CODED_REF)
    else $error("coded reference outside RF window");
  a_phase_at_wrap: assert property ($changed(MIXER_PHASE) |-> ##[0:1] PULSES.period_end)
    else $error("mixer phase moved away from wrap");
endmodule

bind radar_pulse_timing_sequencer pulse_seq_checker chk_u (.MCLK(MCLK), .RST_N(RST_N), .RSYNC_SEL(RSYNC_SEL),
  .RSYNC_WFG(RSYNC_WFG), .RSYNC_STAT(RSYNC_STAT), .PULSES(PULSES), .RANGE_SYNC(RANGE_SYNC),
  .SAMPLE_COMB(SAMPLE_COMB), .CODED_REF(CODED_REF), .RX_GATE(RX_GATE), .MIXER_PHASE(MIXER_PHASE));

/* File: host_cmd_model.sv */
// Host command bus and subsystem sources facing the sequencer
`timescale 1ns/1ps
module host_cmd_model (
  input  wire logic        mclk,
  input  wire logic [31:0] rdata,
  output logic [3:0]       addr,
  output logic [31:0]      wdata,
  output logic             wr,
  output logic             rd,
  output logic             ref_std,
  output logic             ref_wfg,
  output logic             rsync_wfg,
  output logic             rsync_stat,
  output logic             pretrig
);
  logic [11:0] tick_r = 12'h000;
  initial begin
    addr  = 4'h0;
    wdata = 32'h0000_0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Two 5 MHz references, edges kept clear of the clock edges
  initial begin
    ref_std = 1'b0;
    #10;
    forever #100 ref_std = ~ref_std;
  end
  initial begin
    ref_wfg = 1'b0;
    #60;
    forever #100 ref_wfg = ~ref_wfg;
  end
  // Range sync sources differ so a wrong selection shows; pretrigger is periodic
  always @(posedge mclk)
    tick_r <= tick_r + 12'h001;
  assign rsync_wfg  = tick_r[4];
  assign rsync_stat = tick_r[6] ^ tick_r[2];
  assign pretrig    = tick_r[11:4] == 8'h00;
  // Host programs period, event times and phase with one-cycle writes
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  // Read data are taken at the edge closing the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(posedge mclk);
    v = rdata;
  endtask
endmodule

/* File: tb_radar_pulse_timing_sequencer.sv */
// Self-checking bench for the radar pulse timing sequencer
`timescale 1ns/1ps
`include "pulse_seq_defines.svh"
module tb_radar_pulse_timing_sequencer
  import pulse_seq_pkg::*;
;
  typedef struct {logic [3:0] a; int dflt; int us;} row_t;
  logic        MCLK, RST_N, WR, RD, REF_SEL, REF_5M_STD, REF_5M_WFG, RSYNC_SEL, RSYNC_WFG, RSYNC_STAT, PRETRIG;
  logic        RANGE_SYNC, SAMPLE_COMB, CODED_REF, RX_GATE, MIXER_PHASE;
  logic [3:0]  ADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [12:0] CODE_PATTERN;
  pulse_vec_t  PULSES, prev_r = '0;
  logic        comb_prev = 1'b0, ref_prev = 1'b0;
  int          fails = 0, num_checks = 0, cyc = 0, plen = 0, comb_cnt = 0, comb_gap = 0;
  int          ref_rises = 0, pe_seen = 0, comb_seen = 0, r0 = 0, ref_cnt = 0, ref_min = 1000;
  int          rise_at [13] = '{default: -1};
  // Address, default, programmed offset; a 300 us period keeps the run short
  row_t        rows [13] = '{'{4'h0, 37000, 300}, '{4'h1, 10, 1}, '{4'h2, 1800, 10}, '{4'h3, 1820, 12},
    '{4'h4, 1960, 14}, '{4'h5, 3000, 40}, '{4'h6, 3000, 41}, '{4'h7, 3500, 50}, '{4'h8, 11960, 100},
    '{4'h9, 13000, 120}, '{4'hA, 1950, 13}, '{4'hB, 1960, 14}, '{4'hC, 1950, 15}};

  radar_pulse_timing_sequencer dut_u (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .REF_SEL(REF_SEL), .REF_5M_STD(REF_5M_STD), .REF_5M_WFG(REF_5M_WFG), .RSYNC_SEL(RSYNC_SEL),
    .RSYNC_WFG(RSYNC_WFG), .RSYNC_STAT(RSYNC_STAT), .PRETRIG(PRETRIG), .CODE_PATTERN(CODE_PATTERN),
    .PULSES(PULSES), .RANGE_SYNC(RANGE_SYNC), .SAMPLE_COMB(SAMPLE_COMB), .CODED_REF(CODED_REF),
    .RX_GATE(RX_GATE), .MIXER_PHASE(MIXER_PHASE));
  host_cmd_model host_u (.mclk(MCLK), .rdata(RDATA), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD),
    .ref_std(REF_5M_STD), .ref_wfg(REF_5M_WFG), .rsync_wfg(RSYNC_WFG), .rsync_stat(RSYNC_STAT), .pretrig(PRETRIG));

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  // Rise times counted from the last wrap; gaps between comb rises
  always @(posedge MCLK) begin
    prev_r    <= PULSES;
    comb_prev <= SAMPLE_COMB;
    ref_prev  <= CODED_REF;
    cyc       <= cyc + 1;
    comb_cnt  <= comb_cnt + 1;
    if (PULSES.period_end && !prev_r.period_end) begin
      cyc     <= 0;
      plen    <= cyc;
      pe_seen <= pe_seen + 1;
    end
    for (int i = 0; i < 13; i++)
      if (PULSES[i] && !prev_r[i])
        rise_at[i] <= cyc;
    if (SAMPLE_COMB && !comb_prev) begin
      comb_cnt  <= 0;
      comb_gap  <= comb_cnt;
      comb_seen <= comb_seen + 1;
    end
    // Shortest rise-to-rise spacing of the coded reference shows its carrier rate
    ref_cnt <= ref_cnt + 1;
    if (CODED_REF && !ref_prev) begin
      ref_rises <= ref_rises + 1;
      ref_cnt   <= 0;
      if (ref_cnt < ref_min)
        ref_min <= ref_cnt;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  // Bounded wait for a monitor count to advance; running out ends the run
  task automatic wait_cnt(ref int c, input int n, input int lim);
    int goal;
    goal = c + n;
    for (int k = 0; k < lim && c < goal; k++)
      @(posedge MCLK);
    if (c < goal) begin
      fails++;
      $display("unexpected event count expected %0d seen %0d", goal, c);
      report_and_stop();
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    RST_N        = 1'b0;
    REF_SEL      = 1'b0;
    RSYNC_SEL    = 1'b0;
    CODE_PATTERN = `BARKER_CODE;
    repeat (3) @(posedge MCLK);
    RST_N <= 1'b1;
    foreach (rows[k]) begin
      host_u.rd_reg(rows[k].a, d);
      chk("default offset", rows[k].dflt, d[23:0]);
    end
    foreach (rows[k])
      host_u.wr_reg(rows[k].a, rows[k].us);
    wait_cnt(pe_seen, 2, 20000);
    chk("period length", 20 * 300 - 1, plen);
    // Calibration lines stay silent while their enable is clear
    for (int k = 1; k < 13; k++)
      chk("event rise", (k inside {8, 9}) ? -1 : 20 * rows[k].us - 1, rise_at[13 - k]);
    chk("inhibited ref", 0, ref_rises);
    chk("comb gap", 199, comb_gap);
    chk("receive gate", 1, RX_GATE);
    r0 = ref_rises;
    host_u.wr_reg(`A_CTRL, 32'h0010_0005);
    wait_cnt(pe_seen, 2, 20000);
    chk("cal start rise", 20 * 100 - 1, rise_at[5]);
    chk("cal stop rise", 20 * 120 - 1, rise_at[4]);
    chk("unmodulated ref", 1, ref_rises > r0);
    chk("carrier rise gap", 9, ref_min);
    chk("mixer phase", 1, MIXER_PHASE);
    host_u.rd_reg(4'hF, d);
    chk("phase log", 1, d[0]);
    r0 = ref_rises;
    REF_SEL <= 1'b1;
    host_u.wr_reg(`A_CTRL, 32'h0000_0009);
    wait_cnt(pe_seen, 2, 20000);
    chk("coded ref", 1, ref_rises > r0);
    chk("comb gap alt ref", 199, comb_gap);
    chk("mixer phase back", 0, MIXER_PHASE);
    host_u.wr_reg(`A_CTRL, 32'h0000_0002);
    wait_cnt(comb_seen, 3, 40000);
    chk("backup comb gap", 9999, comb_gap);
    // Status is read-only: a write of all ones must not land
    host_u.wr_reg(`A_STATUS, 32'hFFFF_FFFF);
    host_u.rd_reg(`A_STATUS, d);
    chk("status counter", 1, d[23:0] < 24'd300);
    host_u.rd_reg(`A_CTRL, d);
    chk("ctrl after status write", 2, d);
    RST_N     <= 1'b0;
    RSYNC_SEL <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk("outputs in reset", 0, {PULSES, RANGE_SYNC, SAMPLE_COMB, CODED_REF, RX_GATE, MIXER_PHASE});
    RST_N <= 1'b1;
    host_u.rd_reg(`A_PERIOD, d);
    chk("period after reset", 37000, d[23:0]);
    wait_cnt(comb_seen, 3, 2000);
    chk("comb gap after reset", 199, comb_gap);
    report_and_stop();
  end
endmodule
